// ===== hdl/bcit_pkg.sv
// Constants, encodings and types of the instruction decode and timing block
package bcit_pkg;
	// Encoded lengths in bytes
	localparam logic [1:0] LEN_ONE = 2'h1;
	localparam logic [1:0] LEN_TWO = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;
	// Execution lengths in core clock cycles
	localparam logic [2:0] CYC_REG = 3'h1;
	localparam logic [2:0] CYC_MEM = 3'h2;
	localparam logic [2:0] CYC_RMW = 3'h3;
	localparam logic [2:0] CYC_MUL = 3'h2;
	localparam logic [2:0] CYC_DIV = 3'h6;
	localparam logic [2:0] CYC_DA = 3'h3;
	localparam logic [2:0] CYC_XRD8 = 3'h4;
	localparam logic [2:0] CYC_XRD16 = 3'h3;
	localparam logic [2:0] CYC_XWR8 = 3'h5;
	localparam logic [2:0] CYC_XWR16 = 3'h4;
	localparam logic [2:0] CYC_LUT_PTR = 3'h5;
	localparam logic [2:0] CYC_LUT_PC = 3'h4;
	localparam logic [2:0] CYC_PUSH = 3'h3;
	localparam logic [2:0] CYC_POP = 3'h2;
	localparam logic [2:0] CYC_JMP_CARRY = 3'h3;
	localparam logic [2:0] CYC_JMP_BIT = 3'h5;
	localparam logic [2:0] CYC_JMP_SHORT = 3'h3;
	localparam logic [2:0] CYC_JMP_LONG = 3'h4;
	localparam logic [2:0] CYC_JMP_MEM = 3'h5;
	// Decimal adjust thresholds and corrections
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [8:0] BCD_LO_FIX = 9'h006;
	localparam logic [8:0] BCD_HI_FIX = 9'h060;
	// Opcode of the single unassigned code point
	localparam logic [7:0] OPC_UNDEF = 8'hA5;

	typedef enum logic [2:0] {
		CLS_ARITH = 3'h0,
		CLS_LOGIC = 3'h1,
		CLS_XFER = 3'h2,
		CLS_BOOL = 3'h3,
		CLS_BRANCH = 3'h4,
		CLS_UNDEF = 3'h5
	} bcit_class_e;

	typedef enum logic [5:0] {
		OP_NONE = 6'h00, OP_ADD = 6'h01, OP_ADD_CARRY = 6'h02, OP_SUB_BORROW = 6'h03,
		OP_INC = 6'h04, OP_DEC = 6'h05, OP_AND = 6'h06, OP_OR = 6'h07,
		OP_XOR = 6'h08, OP_CLRA = 6'h09, OP_CPLA = 6'h0A, OP_ROL = 6'h0B,
		OP_ROLC = 6'h0C, OP_ROR = 6'h0D, OP_RORC = 6'h0E, OP_SWAP = 6'h0F,
		OP_MUL = 6'h10, OP_DIV = 6'h11, OP_DA = 6'h12, OP_MOVE = 6'h13,
		OP_EXCH = 6'h14, OP_EXCH_LOW = 6'h15, OP_INCDP = 6'h16, OP_LDDP = 6'h17,
		OP_XRD = 6'h18, OP_XWR = 6'h19, OP_CODE = 6'h1A, OP_CLRB = 6'h1B,
		OP_SET_BIT = 6'h1C, OP_CPLB = 6'h1D, OP_ANLC = 6'h1E, OP_ANLCN = 6'h1F,
		OP_ORLC = 6'h20, OP_ORLCN = 6'h21, OP_MOVCB = 6'h22, OP_MOVBC = 6'h23,
		OP_JMP_CY = 6'h24, OP_JMP_NCY = 6'h25, OP_JMP_BIT = 6'h26, OP_JMP_NBIT = 6'h27,
		OP_JMP_BIT_CLR = 6'h28, OP_BRANCH = 6'h29
	} bcit_op_e;

	typedef struct packed {
		logic [1:0] len;
		logic [2:0] cyc;
		bcit_class_e cls;
		bcit_op_e op;
		logic on_c;
		logic wide;
	} bcit_dec_s;
endpackage

// ===== hdl/bcit_core.sv
// Instruction decode, timing and data path of the 8-bit core
//
// Function
// RQ1: Add, add with carry, subtract with borrow on a working register: one byte, one cycle.
// RQ2: Direct or immediate forms: two bytes, two cycles; indirect forms one byte, two cycles.
// RQ3: Increment/decrement: accumulator 1, register 2, direct or indirect 3; pointer increment 1.
// RQ4: Multiply accumulator by auxiliary register: one byte, two cycles.
// RQ5: Divide takes six cycles, decimal adjust three; both one byte.
// RQ6: Byte AND/OR/XOR bitwise; register form one cycle, other forms two.
// RQ7: Logic into a direct byte takes three cycles; two or three bytes long.
// RQ8: Clear, complement and the four rotates of the accumulator: one byte, one cycle.
// RQ9: Nibble exchange of the accumulator: one byte, one cycle.
// RQ10: External data moves only between accumulator and RAM, indirectly addressed.
// RQ11: External reads 4 or 3 cycles, writes 5 or 4 cycles; all one byte.
// RQ12: Code lookups at accumulator plus base; pointer base five cycles, counter base four.
// RQ13: Loading the data pointer with a constant: three bytes, three cycles.
// RQ14: Direct-to-direct move three bytes, three cycles; direct into register three cycles.
// RQ15: Push three cycles, pop two cycles; both two bytes.
// RQ16: Low digit exchange one byte, three cycles; full exchanges two or three cycles.
// RQ17: 128 bits of RAM plus register bits reachable by bit operations.
// RQ18: Carry clear/set/complement one cycle; direct bit operations and carry store three.
// RQ19: Bit AND/OR (or complement) into carry and bit load: two bytes, two cycles.
// RQ20: Jumps on carry set or clear: two bytes, three cycles.
// RQ21: Jumps on a direct bit: three bytes, five cycles; set-and-clear form clears bit.
// RQ22: Direct address 8 bits; indirect via register 0/1 or 16-bit data pointer.
// RQ23: Every opcode of the classic instruction set is decoded.
// RQ24: Cycles count from opcode fetch until next start; instructions never overlap.
// RQ25: Carry, auxiliary carry and overflow follow the classic arithmetic conventions.
`timescale 1ns/10ps
module bcit_core (
	// Clock and reset
	input wire logic I_MCLK,
	input wire logic I_RESET,
	// Instruction start
	input wire logic I_START,
	input wire logic [7:0] I_OPCODE,
	// Operands fetched for the instruction
	input wire logic [7:0] I_ACC,
	input wire logic [7:0] I_SRC,
	input wire logic [7:0] I_DEST,
	input wire logic [7:0] I_BREG,
	input wire logic [15:0] I_DATA_PTR,
	input wire logic I_CY,
	input wire logic I_AC,
	input wire logic I_OV,
	input wire logic I_BIT,
	// Sequencing
	output logic O_READY,
	output logic O_BUSY,
	output logic O_DONE,
	// Decode results
	output logic [1:0] O_LENGTH,
	output logic [2:0] O_CYCLES,
	output bcit_pkg::bcit_class_e O_CLASS,
	output logic O_UNDEFINED,
	// Data results
	output logic [7:0] O_RESULT,
	output logic [7:0] O_AUX,
	output logic [15:0] O_DATA_PTR,
	output logic O_CY,
	output logic O_AC,
	output logic O_OV,
	output logic O_BIT,
	output logic O_BIT_WR,
	output logic O_TAKEN,
	// Memory access kind
	output logic O_XDATA_RD,
	output logic O_XDATA_WR,
	output logic O_XDATA_WIDE,
	output logic O_CODE_RD
);
	import bcit_pkg::*;

	typedef struct packed {
		logic busy;
		logic done;
		logic [2:0] remain;
		logic [1:0] len;
		logic [2:0] cyc;
		bcit_class_e cls;
		logic undef;
		logic [7:0] res;
		logic [7:0] aux;
		logic [15:0] data_ptr;
		logic cy;
		logic ac;
		logic ov;
		logic bit_val;
		logic bit_wr;
		logic taken;
		logic xrd;
		logic xwr;
		logic xwide;
		logic code_rd;
	} bcit_state_s;

	bcit_state_s state;
	bcit_state_s next_state;
	bcit_dec_s dec;

	function automatic bcit_dec_s mk(input logic [1:0] len, input logic [2:0] cyc,
		input bcit_class_e cls, input bcit_op_e op, input logic on_c, input logic wide);
		mk.len = len;
		mk.cyc = cyc;
		mk.cls = cls;
		mk.op = op;
		mk.on_c = on_c;
		mk.wide = wide;
	endfunction

	// Full opcode map; on_c marks carry targets or direct-byte destinations
	function automatic bcit_dec_s decode(input logic [7:0] opc);
		decode = mk(LEN_ONE, CYC_REG, CLS_BRANCH, OP_NONE, 1'b0, 1'b0);
		casez (opc) // [RQ23]
			8'h00: decode = mk(LEN_ONE, CYC_REG, CLS_BRANCH, OP_NONE, 1'b0, 1'b0);
			8'b???0_0001: decode = mk(LEN_TWO, CYC_JMP_SHORT, CLS_BRANCH, OP_BRANCH, 1'b0, 1'b0);
			8'b???1_0001: decode = mk(LEN_TWO, CYC_JMP_LONG, CLS_BRANCH, OP_BRANCH, 1'b0, 1'b0);
			8'h02, 8'h12: decode = mk(LEN_THREE, CYC_JMP_LONG, CLS_BRANCH, OP_BRANCH, 1'b0, 1'b0);
			8'h22, 8'h32: decode = mk(LEN_ONE, CYC_JMP_LONG, CLS_BRANCH, OP_BRANCH, 1'b0, 1'b0);
			8'h03: decode = mk(LEN_ONE, CYC_REG, CLS_LOGIC, OP_ROR, 1'b0, 1'b0); // [RQ8]
			8'h13: decode = mk(LEN_ONE, CYC_REG, CLS_LOGIC, OP_RORC, 1'b0, 1'b0); // [RQ8]
			8'h23: decode = mk(LEN_ONE, CYC_REG, CLS_LOGIC, OP_ROL, 1'b0, 1'b0); // [RQ8]
			8'h33: decode = mk(LEN_ONE, CYC_REG, CLS_LOGIC, OP_ROLC, 1'b0, 1'b0); // [RQ8]
			8'h04: decode = mk(LEN_ONE, CYC_REG, CLS_ARITH, OP_INC, 1'b0, 1'b0); // [RQ3]
			8'h14: decode = mk(LEN_ONE, CYC_REG, CLS_ARITH, OP_DEC, 1'b0, 1'b0); // [RQ3]
			8'h05: decode = mk(LEN_TWO, CYC_RMW, CLS_ARITH, OP_INC, 1'b0, 1'b0); // [RQ3]
			8'h15: decode = mk(LEN_TWO, CYC_RMW, CLS_ARITH, OP_DEC, 1'b0, 1'b0); // [RQ3]
			8'b0000_011?: decode = mk(LEN_ONE, CYC_RMW, CLS_ARITH, OP_INC, 1'b0, 1'b0); // [RQ3]
			8'b0001_011?: decode = mk(LEN_ONE, CYC_RMW, CLS_ARITH, OP_DEC, 1'b0, 1'b0); // [RQ3]
			8'b0000_1???: decode = mk(LEN_ONE, CYC_MEM, CLS_ARITH, OP_INC, 1'b0, 1'b0); // [RQ3]
			8'b0001_1???: decode = mk(LEN_ONE, CYC_MEM, CLS_ARITH, OP_DEC, 1'b0, 1'b0); // [RQ3]
			8'h10: decode = mk(LEN_THREE, CYC_JMP_BIT, CLS_BOOL, OP_JMP_BIT_CLR, 1'b0, 1'b0); // [RQ21]
			8'h20: decode = mk(LEN_THREE, CYC_JMP_BIT, CLS_BOOL, OP_JMP_BIT, 1'b0, 1'b0); // [RQ21]
			8'h30: decode = mk(LEN_THREE, CYC_JMP_BIT, CLS_BOOL, OP_JMP_NBIT, 1'b0, 1'b0); // [RQ21]
			8'h40: decode = mk(LEN_TWO, CYC_JMP_CARRY, CLS_BOOL, OP_JMP_CY, 1'b0, 1'b0); // [RQ20]
			8'h50: decode = mk(LEN_TWO, CYC_JMP_CARRY, CLS_BOOL, OP_JMP_NCY, 1'b0, 1'b0); // [RQ20]
			8'h60, 8'h70: decode = mk(LEN_TWO, CYC_JMP_LONG, CLS_BRANCH, OP_BRANCH, 1'b0, 1'b0);
			8'h80: decode = mk(LEN_TWO, CYC_JMP_SHORT, CLS_BRANCH, OP_BRANCH, 1'b0, 1'b0);
			8'h73: decode = mk(LEN_ONE, CYC_JMP_MEM, CLS_BRANCH, OP_BRANCH, 1'b0, 1'b0);
			8'hB4, 8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF:
				decode = mk(LEN_THREE, CYC_JMP_LONG, CLS_BRANCH, OP_BRANCH, 1'b0, 1'b0);
			8'hB5, 8'hB6, 8'hB7, 8'hD5:
				decode = mk(LEN_THREE, CYC_JMP_MEM, CLS_BRANCH, OP_BRANCH, 1'b0, 1'b0);
			8'b1101_1???: decode = mk(LEN_TWO, CYC_JMP_LONG, CLS_BRANCH, OP_BRANCH, 1'b0, 1'b0);
			// Add, add with carry, subtract with borrow
			8'h24, 8'h34, 8'h94, 8'h25, 8'h35, 8'h95:
				decode = mk(LEN_TWO, CYC_MEM, CLS_ARITH,
					bcit_op_e'(opc[7] ? OP_SUB_BORROW : (opc[4] ? OP_ADD_CARRY : OP_ADD)),
					1'b0, 1'b0); // [RQ2]
			8'b0010_011?, 8'b0011_011?, 8'b1001_011?:
				decode = mk(LEN_ONE, CYC_MEM, CLS_ARITH,
					bcit_op_e'(opc[7] ? OP_SUB_BORROW : (opc[4] ? OP_ADD_CARRY : OP_ADD)),
					1'b0, 1'b0); // [RQ2]
			8'b0010_1???, 8'b0011_1???, 8'b1001_1???:
				decode = mk(LEN_ONE, CYC_REG, CLS_ARITH,
					bcit_op_e'(opc[7] ? OP_SUB_BORROW : (opc[4] ? OP_ADD_CARRY : OP_ADD)),
					1'b0, 1'b0); // [RQ1]
			// OR, AND, XOR rows
			8'h42, 8'h52, 8'h62:
				decode = mk(LEN_TWO, CYC_RMW, CLS_LOGIC, bcit_op_e'(opc[5] ? OP_XOR : (opc[4] ? OP_AND : OP_OR)),
					1'b1, 1'b0); // [RQ7]
			8'h43, 8'h53, 8'h63:
				decode = mk(LEN_THREE, CYC_RMW, CLS_LOGIC, bcit_op_e'(opc[5] ? OP_XOR : (opc[4] ? OP_AND : OP_OR)),
					1'b1, 1'b0); // [RQ7]
			8'h44, 8'h54, 8'h64, 8'h45, 8'h55, 8'h65:
				decode = mk(LEN_TWO, CYC_MEM, CLS_LOGIC, bcit_op_e'(opc[5] ? OP_XOR : (opc[4] ? OP_AND : OP_OR)),
					1'b0, 1'b0); // [RQ6]
			8'b0100_011?, 8'b0101_011?, 8'b0110_011?:
				decode = mk(LEN_ONE, CYC_MEM, CLS_LOGIC, bcit_op_e'(opc[5] ? OP_XOR : (opc[4] ? OP_AND : OP_OR)),
					1'b0, 1'b0); // [RQ6]
			8'b0100_1???, 8'b0101_1???, 8'b0110_1???:
				decode = mk(LEN_ONE, CYC_REG, CLS_LOGIC, bcit_op_e'(opc[5] ? OP_XOR : (opc[4] ? OP_AND : OP_OR)),
					1'b0, 1'b0); // [RQ6]
			// Bit operations on carry and direct bits
			8'h72: decode = mk(LEN_TWO, CYC_MEM, CLS_BOOL, OP_ORLC, 1'b1, 1'b0); // [RQ19]
			8'hA0: decode = mk(LEN_TWO, CYC_MEM, CLS_BOOL, OP_ORLCN, 1'b1, 1'b0); // [RQ19]
			8'h82: decode = mk(LEN_TWO, CYC_MEM, CLS_BOOL, OP_ANLC, 1'b1, 1'b0); // [RQ19]
			8'hB0: decode = mk(LEN_TWO, CYC_MEM, CLS_BOOL, OP_ANLCN, 1'b1, 1'b0); // [RQ19]
			8'hA2: decode = mk(LEN_TWO, CYC_MEM, CLS_BOOL, OP_MOVCB, 1'b1, 1'b0); // [RQ19]
			8'h92: decode = mk(LEN_TWO, CYC_RMW, CLS_BOOL, OP_MOVBC, 1'b0, 1'b0); // [RQ18]
			8'hB2: decode = mk(LEN_TWO, CYC_RMW, CLS_BOOL, OP_CPLB, 1'b0, 1'b0); // [RQ18]
			8'hC2: decode = mk(LEN_TWO, CYC_RMW, CLS_BOOL, OP_CLRB, 1'b0, 1'b0); // [RQ18]
			8'hD2: decode = mk(LEN_TWO, CYC_RMW, CLS_BOOL, OP_SET_BIT, 1'b0, 1'b0); // [RQ18]
			8'hB3: decode = mk(LEN_ONE, CYC_REG, CLS_BOOL, OP_CPLB, 1'b1, 1'b0); // [RQ18]
			8'hC3: decode = mk(LEN_ONE, CYC_REG, CLS_BOOL, OP_CLRB, 1'b1, 1'b0); // [RQ18]
			8'hD3: decode = mk(LEN_ONE, CYC_REG, CLS_BOOL, OP_SET_BIT, 1'b1, 1'b0); // [RQ18]
			// Multiply, divide, decimal adjust, pointer increment
			8'hA4: decode = mk(LEN_ONE, CYC_MUL, CLS_ARITH, OP_MUL, 1'b0, 1'b0); // [RQ4]
			8'h84: decode = mk(LEN_ONE, CYC_DIV, CLS_ARITH, OP_DIV, 1'b0, 1'b0); // [RQ5]
			8'hD4: decode = mk(LEN_ONE, CYC_DA, CLS_ARITH, OP_DA, 1'b0, 1'b0); // [RQ5]
			8'hA3: decode = mk(LEN_ONE, CYC_REG, CLS_ARITH, OP_INCDP, 1'b0, 1'b0); // [RQ3]
			// Data transfers
			8'h74, 8'h76, 8'h77, 8'b0111_1???, 8'hE5, 8'hF5, 8'b1000_1???, 8'hF6, 8'hF7, 8'hE6, 8'hE7:
				// Only the accumulator and indirect pairs E6/E7/F6/F7 are one byte long
				decode = mk((~opc[3] & opc[7] & opc[6] & opc[1]) ? LEN_ONE : LEN_TWO, CYC_MEM, CLS_XFER, OP_MOVE,
					1'b0, 1'b0); // [RQ14]
			8'b1110_1???, 8'b1111_1???: decode = mk(LEN_ONE, CYC_REG, CLS_XFER, OP_MOVE, 1'b0, 1'b0);
			8'h75, 8'h85: decode = mk(LEN_THREE, CYC_RMW, CLS_XFER, OP_MOVE, 1'b0, 1'b0); // [RQ14]
			8'h86, 8'h87, 8'hA6, 8'hA7, 8'b1010_1???:
				decode = mk(LEN_TWO, CYC_RMW, CLS_XFER, OP_MOVE, 1'b0, 1'b0); // [RQ14] [RQ22]
			8'h90: decode = mk(LEN_THREE, CYC_RMW, CLS_XFER, OP_LDDP, 1'b0, 1'b0); // [RQ13]
			8'h93: decode = mk(LEN_ONE, CYC_LUT_PTR, CLS_XFER, OP_CODE, 1'b0, 1'b1); // [RQ12]
			8'h83: decode = mk(LEN_ONE, CYC_LUT_PC, CLS_XFER, OP_CODE, 1'b0, 1'b0); // [RQ12]
			8'hE0: decode = mk(LEN_ONE, CYC_XRD16, CLS_XFER, OP_XRD, 1'b0, 1'b1); // [RQ11]
			8'hE2, 8'hE3: decode = mk(LEN_ONE, CYC_XRD8, CLS_XFER, OP_XRD, 1'b0, 1'b0); // [RQ11]
			8'hF0: decode = mk(LEN_ONE, CYC_XWR16, CLS_XFER, OP_XWR, 1'b0, 1'b1); // [RQ11]
			8'hF2, 8'hF3: decode = mk(LEN_ONE, CYC_XWR8, CLS_XFER, OP_XWR, 1'b0, 1'b0); // [RQ11]
			8'hC0: decode = mk(LEN_TWO, CYC_PUSH, CLS_XFER, OP_MOVE, 1'b0, 1'b0); // [RQ15]
			8'hD0: decode = mk(LEN_TWO, CYC_POP, CLS_XFER, OP_MOVE, 1'b0, 1'b0); // [RQ15]
			8'hC5: decode = mk(LEN_TWO, CYC_RMW, CLS_XFER, OP_EXCH, 1'b0, 1'b0); // [RQ16]
			8'hC6, 8'hC7: decode = mk(LEN_ONE, CYC_RMW, CLS_XFER, OP_EXCH, 1'b0, 1'b0); // [RQ16]
			8'b1100_1???: decode = mk(LEN_ONE, CYC_MEM, CLS_XFER, OP_EXCH, 1'b0, 1'b0); // [RQ16]
			8'hD6, 8'hD7: decode = mk(LEN_ONE, CYC_RMW, CLS_XFER, OP_EXCH_LOW, 1'b0, 1'b0); // [RQ16]
			// Accumulator-only operations
			8'hC4: decode = mk(LEN_ONE, CYC_REG, CLS_LOGIC, OP_SWAP, 1'b0, 1'b0); // [RQ9]
			8'hE4: decode = mk(LEN_ONE, CYC_REG, CLS_LOGIC, OP_CLRA, 1'b0, 1'b0); // [RQ8]
			8'hF4: decode = mk(LEN_ONE, CYC_REG, CLS_LOGIC, OP_CPLA, 1'b0, 1'b0); // [RQ8]
			OPC_UNDEF: decode = mk(LEN_ONE, CYC_REG, CLS_UNDEF, OP_NONE, 1'b0, 1'b0);
			default: decode = mk(LEN_ONE, CYC_REG, CLS_BRANCH, OP_NONE, 1'b0, 1'b0);
		endcase
	endfunction

	always_comb begin
		logic [8:0] sum;
		logic [4:0] half;
		logic [7:0] lhs;
		logic [7:0] rhs;
		logic [15:0] prod;
		sum = 9'h000;
		half = 5'h00;
		prod = 16'h0000;
		dec = decode(I_OPCODE);
		// Direct-byte destinations take the memory byte as left operand
		lhs = (dec.on_c && dec.cls == CLS_LOGIC) ? I_DEST : I_ACC;
		// Logic into a direct byte: even codes take the accumulator, odd ones the immediate
		rhs = (dec.on_c && dec.cls == CLS_LOGIC && !I_OPCODE[0]) ? I_ACC : I_SRC; // [RQ7]
		next_state = state;
		next_state.done = 1'b0;
		if (state.busy) begin
			next_state.remain = state.remain - 3'h1; // [RQ24]
			if (state.remain == 3'h1) begin
				next_state.busy = 1'b0;
				next_state.done = 1'b1;
			end
		end else if (I_START) begin
			next_state.busy = (dec.cyc != CYC_REG);
			next_state.done = (dec.cyc == CYC_REG);
			next_state.remain = dec.cyc - 3'h1;
			next_state.len = dec.len;
			next_state.cyc = dec.cyc;
			next_state.cls = dec.cls;
			next_state.undef = (dec.cls == CLS_UNDEF);
			next_state.res = I_ACC;
			next_state.aux = I_DEST;
			next_state.data_ptr = I_DATA_PTR;
			next_state.cy = I_CY;
			next_state.ac = I_AC;
			next_state.ov = I_OV;
			next_state.bit_val = I_BIT;
			next_state.bit_wr = 1'b0;
			next_state.taken = 1'b0;
			next_state.xrd = (dec.op == OP_XRD); // [RQ10]
			next_state.xwr = (dec.op == OP_XWR); // [RQ10]
			next_state.xwide = dec.wide; // [RQ22]
			next_state.code_rd = (dec.op == OP_CODE);
			case (dec.op)
				OP_ADD, OP_ADD_CARRY: begin
					sum = {1'b0, I_ACC} + {1'b0, I_SRC} + {8'h00, dec.op == OP_ADD_CARRY && I_CY};
					half = {1'b0, I_ACC[3:0]} + {1'b0, I_SRC[3:0]} + {4'h0, dec.op == OP_ADD_CARRY && I_CY};
					next_state.res = sum[7:0];
					next_state.cy = sum[8]; // [RQ25]
					next_state.ac = half[4]; // [RQ25]
					next_state.ov = (I_ACC[7] == I_SRC[7]) && (sum[7] != I_ACC[7]); // [RQ25]
				end
				OP_SUB_BORROW: begin
					sum = {1'b0, I_ACC} - {1'b0, I_SRC} - {8'h00, I_CY};
					half = {1'b0, I_ACC[3:0]} - {1'b0, I_SRC[3:0]} - {4'h0, I_CY};
					next_state.res = sum[7:0];
					next_state.cy = sum[8]; // [RQ25]
					next_state.ac = half[4]; // [RQ25]
					next_state.ov = (I_ACC[7] != I_SRC[7]) && (sum[7] != I_ACC[7]); // [RQ25]
				end
				OP_INC: next_state.res = I_SRC + 8'h01;
				OP_DEC: next_state.res = I_SRC - 8'h01;
				OP_INCDP: next_state.data_ptr = I_DATA_PTR + 16'h0001; // [RQ3]
				OP_AND: next_state.res = lhs & rhs; // [RQ6] [RQ7]
				OP_OR: next_state.res = lhs | rhs; // [RQ6] [RQ7]
				OP_XOR: next_state.res = lhs ^ rhs; // [RQ6] [RQ7]
				OP_CLRA: next_state.res = 8'h00; // [RQ8]
				OP_CPLA: next_state.res = ~I_ACC; // [RQ8]
				OP_ROL: next_state.res = {I_ACC[6:0], I_ACC[7]}; // [RQ8]
				OP_ROR: next_state.res = {I_ACC[0], I_ACC[7:1]}; // [RQ8]
				OP_ROLC: begin
					next_state.res = {I_ACC[6:0], I_CY}; // [RQ8]
					next_state.cy = I_ACC[7];
				end
				OP_RORC: begin
					next_state.res = {I_CY, I_ACC[7:1]}; // [RQ8]
					next_state.cy = I_ACC[0];
				end
				OP_SWAP: next_state.res = {I_ACC[3:0], I_ACC[7:4]}; // [RQ9]
				OP_MUL: begin
					prod = I_ACC * I_BREG; // [RQ4]
					next_state.res = prod[7:0];
					next_state.aux = prod[15:8];
					next_state.cy = 1'b0; // [RQ25]
					next_state.ov = (prod[15:8] != 8'h00); // [RQ25]
				end
				OP_DIV: begin
					// Zero divisor leaves operands as they were and flags overflow
					next_state.res = (I_BREG == 8'h00) ? I_ACC : I_ACC / I_BREG; // [RQ5]
					next_state.aux = (I_BREG == 8'h00) ? I_BREG : I_ACC % I_BREG;
					next_state.cy = 1'b0; // [RQ25]
					next_state.ov = (I_BREG == 8'h00); // [RQ25]
				end
				OP_DA: begin
					sum = {1'b0, I_ACC};
					if (I_ACC[3:0] > BCD_MAX || I_AC) begin
						sum = sum + BCD_LO_FIX; // [RQ5]
					end
					if (sum[7:4] > BCD_MAX || sum[8] || I_CY) begin
						sum = sum + BCD_HI_FIX;
					end
					next_state.res = sum[7:0];
					next_state.cy = sum[8] | I_CY; // [RQ25]
				end
				OP_MOVE, OP_XRD, OP_XWR, OP_CODE: next_state.res = I_SRC; // [RQ10] [RQ12]
				OP_LDDP: next_state.data_ptr = I_DATA_PTR; // [RQ13]
				OP_EXCH: begin
					next_state.res = I_SRC; // [RQ16]
					next_state.aux = I_ACC;
				end
				OP_EXCH_LOW: begin
					next_state.res = {I_ACC[7:4], I_SRC[3:0]}; // [RQ16]
					next_state.aux = {I_SRC[7:4], I_ACC[3:0]};
				end
				OP_CLRB, OP_SET_BIT, OP_CPLB: begin
					// Carry forms reuse these codes; only direct bits raise the write
					if (dec.on_c) begin
						next_state.cy = (dec.op == OP_SET_BIT) | ((dec.op == OP_CPLB) & ~I_CY); // [RQ18]
					end else begin
						next_state.bit_val = (dec.op == OP_SET_BIT) | ((dec.op == OP_CPLB) & ~I_BIT); // [RQ17]
						next_state.bit_wr = 1'b1; // [RQ18]
					end
				end
				OP_ANLC: next_state.cy = I_CY & I_BIT; // [RQ19]
				OP_ANLCN: next_state.cy = I_CY & ~I_BIT; // [RQ19]
				OP_ORLC: next_state.cy = I_CY | I_BIT; // [RQ19]
				OP_ORLCN: next_state.cy = I_CY | ~I_BIT; // [RQ19]
				OP_MOVCB: next_state.cy = I_BIT; // [RQ19]
				OP_MOVBC: begin
					next_state.bit_val = I_CY; // [RQ18]
					next_state.bit_wr = 1'b1;
				end
				OP_JMP_CY: next_state.taken = I_CY; // [RQ20]
				OP_JMP_NCY: next_state.taken = ~I_CY; // [RQ20]
				OP_JMP_BIT: next_state.taken = I_BIT; // [RQ21]
				OP_JMP_NBIT: next_state.taken = ~I_BIT; // [RQ21]
				OP_JMP_BIT_CLR: begin
					next_state.taken = I_BIT; // [RQ21]
					next_state.bit_val = 1'b0;
					next_state.bit_wr = I_BIT; // [RQ21]
				end
				default: next_state.res = I_ACC;
			endcase
		end
	end

	always_ff @(posedge I_MCLK or posedge I_RESET) begin
		if (I_RESET) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Start is refused while an instruction is running, so nothing overlaps
	assign O_READY = ~state.busy; // [RQ24]
	assign O_BUSY = state.busy;
	assign O_DONE = state.done;
	assign O_LENGTH = state.len;
	assign O_CYCLES = state.cyc;
	assign O_CLASS = state.cls;
	assign O_UNDEFINED = state.undef;
	assign O_RESULT = state.res;
	assign O_AUX = state.aux;
	assign O_DATA_PTR = state.data_ptr;
	assign O_CY = state.cy;
	assign O_AC = state.ac;
	assign O_OV = state.ov;
	assign O_BIT = state.bit_val;
	assign O_BIT_WR = state.bit_wr;
	assign O_TAKEN = state.taken;
	assign O_XDATA_RD = state.xrd;
	assign O_XDATA_WR = state.xwr;
	assign O_XDATA_WIDE = state.xwide;
	assign O_CODE_RD = state.code_rd;
endmodule

// ===== verification/bcit_core_checker.sv
// Port assertions of the instruction decode and timing block
`timescale 1ns/10ps
module bcit_core_checker (
	// Clock, reset and start
	input wire logic I_MCLK,
	input wire logic I_RESET,
	input wire logic I_START,
	input wire logic [7:0] I_OPCODE,
	// Sequencing and decode
	input wire logic O_READY,
	input wire logic O_BUSY,
	input wire logic O_DONE,
	input wire logic [1:0] O_LENGTH,
	input wire logic [2:0] O_CYCLES,
	input wire logic O_XDATA_WR,
	input wire logic O_XDATA_WIDE
);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (I_RESET);
	sequence s_take(logic [7:0] op);
		I_START && O_READY && I_OPCODE == op;
	endsequence
	sequence s_end;
		O_DONE && !O_BUSY;
	endsequence
	ready_not_busy_a: assert property (O_READY == !O_BUSY) else $error("ready and busy disagree");
	add_reg_a: assert property (s_take(8'h28) |=> s_end ##0 (O_LENGTH == 2'h1 && O_CYCLES == 3'h1))
		else $error("register add not one cycle");
	add_direct_a: assert property (s_take(8'h25) |=> (O_BUSY && O_LENGTH == 2'h2) ##1 s_end)
		else $error("direct add not two cycles");
	inc_direct_a: assert property (s_take(8'h05) |=> O_BUSY[*2] ##1 s_end) else $error("direct increment length");
	mul_two_a: assert property (s_take(8'hA4) |=> O_BUSY ##1 s_end) else $error("multiply not two cycles");
	div_six_a: assert property (s_take(8'h84) |=> O_BUSY[*5] ##1 s_end) else $error("divide not six cycles");
	xwrite_narrow_a: assert property (s_take(8'hF2) |=> (O_XDATA_WR && !O_XDATA_WIDE && O_BUSY)[*4] ##1 s_end)
		else $error("narrow external write timing");
	code_ptr_a: assert property (s_take(8'h93) |=> O_BUSY[*4] ##1 s_end) else $error("pointer lookup timing");
	jump_bit_a: assert property (s_take(8'h20) |=> (O_LENGTH == 2'h3 && O_BUSY)[*4] ##1 s_end)
		else $error("bit jump timing");
	done_pulse_a: assert property (O_DONE && !I_START |=> !O_DONE) else $error("done longer than a cycle");
	refuse_busy_a: assert property (O_BUSY && I_START |=> $stable(O_CYCLES)) else $error("start taken while busy");
endmodule
bind bcit_core bcit_core_checker bcit_core_checker_i (.I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_START(I_START),
	.I_OPCODE(I_OPCODE), .O_READY(O_READY), .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_LENGTH(O_LENGTH),
	.O_CYCLES(O_CYCLES), .O_XDATA_WR(O_XDATA_WR), .O_XDATA_WIDE(O_XDATA_WIDE));

// ===== verification/bcit_mem_model.sv
// Operand memory model standing in for the RAMs
`timescale 1ns/10ps
module bcit_mem_model (
	// Byte address
	input wire logic [7:0] i_addr,
	// Read data
	output logic [7:0] o_data
);
	logic [7:0] mem [256];
	// Complement of the address, so a byte never reads back its own index
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = ~8'(i);
		end
	end
	assign o_data = mem[i_addr];
endmodule

// ===== verification/byte_cpu_instruction_timing_bench.sv
// Self-checking bench of the instruction decode and timing block
`timescale 1ns/10ps
module byte_cpu_instruction_timing_bench;
	import bcit_pkg::*;
	logic clk = 1'h0, rst = 1'h1, start = 1'h0, cy = 1'h0, bitv = 1'h0;
	logic [7:0] opc = 8'h00, acc = 8'h00, addr = 8'h00, src, res, aux;
	logic busy, done, und, cyo, aco, ovo, bito, bwr, tkn, xrd, xwr, xwd, crd;
	bcit_class_e clso;
	logic [1:0] len;
	logic [2:0] cyc;
	logic [15:0] dpo;
	int err_count = 0, compares = 0, n;
	logic [15:0] tbl [54] = '{16'h2811, 16'h3811, 16'h9811, 16'h2522, 16'h2612, 16'h2422, 16'h9422, 16'h0411,
		16'h0812, 16'h0523, 16'h0613, 16'h1411, 16'hA311, 16'hA412, 16'h8416, 16'hD413, 16'h5811, 16'h5612,
		16'h5422, 16'h5223, 16'h6333, 16'hE411, 16'hF411, 16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hC411,
		16'hE214, 16'hE013, 16'hF215, 16'hF014, 16'h9315, 16'h8314, 16'h9033, 16'h8533, 16'hA823, 16'hC023,
		16'hD022, 16'hD613, 16'hC812, 16'hC613, 16'hC311, 16'hD223, 16'h9223, 16'h8222, 16'hB022, 16'hA222,
		16'h4023, 16'h5023, 16'h2035, 16'h3035, 16'h1035, 16'hA511};
	bcit_mem_model bcit_mem_model_i (.i_addr(addr), .o_data(src));
	bcit_core bcit_core_i (.I_MCLK(clk), .I_RESET(rst), .I_START(start), .I_OPCODE(opc), .I_ACC(acc),
		.I_SRC(src), .I_DEST(8'h3C), .I_BREG(8'h0D), .I_DATA_PTR(16'h12FF), .I_CY(cy), .I_AC(1'h0), .I_OV(1'h0),
		.I_BIT(bitv), .O_READY(), .O_BUSY(busy), .O_DONE(done), .O_LENGTH(len), .O_CYCLES(cyc),
		.O_CLASS(clso), .O_UNDEFINED(und), .O_RESULT(res), .O_AUX(aux), .O_DATA_PTR(dpo), .O_CY(cyo), .O_AC(aco),
		.O_OV(ovo), .O_BIT(bito), .O_BIT_WR(bwr), .O_TAKEN(tkn), .O_XDATA_RD(xrd), .O_XDATA_WR(xwr),
		.O_XDATA_WIDE(xwd), .O_CODE_RD(crd));
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Start one instruction, count cycles up to the done pulse
	task automatic run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] s, input logic c);
		@(posedge clk);
		opc <= op;
		acc <= a;
		addr <= s;
		cy <= c;
		bitv <= c;
		start <= 1'h1;
		@(posedge clk);
		start <= 1'h0;
		#1;
		n = 1;
		while (done !== 1'h1) begin
			if (n > 6) begin
				chk(n, 0);
				summarize();
			end
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	task automatic t_timing();
		foreach (tbl[i]) begin
			run(tbl[i][15:8], 8'h00, 8'h00, 1'h0);
			chk({len, cyc}, {tbl[i][5:4], tbl[i][2:0]});
			chk(n, tbl[i][3:0]);
		end
		$display("timing table test done");
	endtask
	// Held start during a divide must wait for the done cycle
	task automatic t_refuse();
		@(posedge clk);
		opc <= 8'h84;
		start <= 1'h1;
		@(posedge clk);
		opc <= 8'h28;
		repeat (4) @(posedge clk);
		#1;
		chk({busy, cyc}, {1'h1, 3'h6});
		@(posedge clk);
		#1;
		chk({done, cyc}, {1'h1, 3'h6});
		@(posedge clk);
		start <= 1'h0;
		#1;
		chk({done, cyc}, {1'h1, 3'h1});
		$display("refused start test done");
	endtask
	task automatic t_data();
		run(8'hA4, 8'hC8, 8'h00, 1'h1);
		chk({res, aux, cyo, ovo}, {16'h280A, 2'h1});
		run(8'h84, 8'hC8, 8'h00, 1'h1);
		chk({res, aux, cyo, ovo}, {16'h0F05, 2'h0});
		run(8'h28, 8'h7F, 8'hFE, 1'h0);
		chk({res, cyo, aco, ovo}, {8'h80, 3'h3});
		run(8'h68, 8'hA5, 8'hF0, 1'h0);
		chk(res, 8'hAA);
		run(8'hC4, 8'h3C, 8'h00, 1'h0);
		chk(res, 8'hC3);
		run(8'h13, 8'h02, 8'h00, 1'h1);
		chk({res, cyo}, {8'h81, 1'h0});
		run(8'h52, 8'hF0, 8'h00, 1'h0);
		chk(res, 8'h30);
		run(8'hA3, 8'h00, 8'h00, 1'h0);
		chk(dpo, 16'h1300);
		run(8'h10, 8'h00, 8'h00, 1'h1);
		chk({tkn, bwr, bito}, 3'h6);
		run(8'h40, 8'h00, 8'h00, 1'h1);
		chk(tkn, 1'h1);
		run(8'hC3, 8'h00, 8'h00, 1'h1);
		chk(cyo, 1'h0);
		run(8'hB0, 8'h00, 8'h00, 1'h1);
		chk(cyo, 1'h0);
		run(8'hF2, 8'h00, 8'h00, 1'h0);
		chk({xrd, xwr, xwd}, 3'h2);
		run(8'hE0, 8'h00, 8'h00, 1'h0);
		chk({xrd, xwr, xwd}, 3'h5);
		run(8'h93, 8'h00, 8'h00, 1'h0);
		chk({crd, xwd, 3'(clso)}, {2'h3, 3'h2});
		run(8'hE5, 8'h00, 8'h00, 1'h0);
		chk({len, res}, {2'h2, 8'hFF});
		run(8'hA5, 8'h00, 8'h00, 1'h0);
		chk(und, 1'h1);
		$display("data path test done");
	endtask
	initial begin
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		t_timing();
		t_refuse();
		t_data();
		summarize();
	end
endmodule
